//--- dv/host_model.sv
// Host software model: acknowledges completions by writing a descriptor
// address to one channel's completion pointer, one strobe per call.
// Assumes the block takes the strobe on the rising clock edge.

`default_nettype none

module host_model (
  // Clock
  input  wire logic        clock,
  // Transmit acknowledge
  output var  logic        tx_host_write,
  output var  logic [2:0]  tx_host_channel,
  output var  logic [31:0] tx_host_address,
  // Receive acknowledge
  output var  logic        rx_host_write,
  output var  logic [2:0]  rx_host_channel,
  output var  logic [31:0] rx_host_address
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tx_host_write   = 1'h0;
    rx_host_write   = 1'h0;
    tx_host_channel = 3'h0;
    rx_host_channel = 3'h0;
    tx_host_address = 32'hFFFFFFFF;
    rx_host_address = 32'hFFFFFFFF;
  end

  // Only the last processed address is written, so one call may stand for
  // several packets handled at once.
  task automatic ack(input bit rx, input logic [2:0] ch,
                     input logic [31:0] a);
    @(negedge clock);
    tx_host_write   = !rx;
    rx_host_write   = rx;
    tx_host_channel = ch;
    rx_host_channel = ch;
    tx_host_address = a;
    rx_host_address = a;
    @(negedge clock);
    tx_host_write   = 1'h0;
    rx_host_write   = 1'h0;
    // A released address shows its inverse so a stale value never matches.
    tx_host_address = ~a;
    rx_host_address = ~a;
  endtask
endmodule

`default_nettype wire

//--- dv/tb_mac_dma_completion_irq_logic.sv
// Self-checking bench for the DMA completion and threshold interrupts.
// Assumes host_model drives the acknowledge ports; all else is driven here.

`default_nettype none

module tb_mac_dma_completion_irq_logic;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock, reset, tx_dma_write, rx_dma_write, tx_host_write;
  logic rx_host_write, descriptor_error_event, soft_reset;
  logic counter_overflow_irq, descriptor_error_irq;
  logic [2:0] tx_dma_channel, tx_host_channel, tx_read_channel;
  logic [2:0] rx_dma_channel, rx_host_channel, rx_read_channel;
  logic [31:0] tx_dma_address, tx_host_address, tx_completion_pointer;
  logic [31:0] rx_dma_address, rx_host_address, rx_completion_pointer;
  logic tx_irq_enable_set_write, tx_irq_enable_clear_write;
  logic rx_irq_enable_set_write, rx_irq_enable_clear_write;
  logic misc_irq_enable_set_write, misc_irq_enable_clear_write;
  logic [7:0] tx_irq_enable_set, tx_irq_enable_clear, tx_irq_enable;
  logic [7:0] rx_irq_enable_set, rx_irq_enable_clear, rx_irq_enable;
  logic [7:0] tx_irq_raw_status, rx_irq_raw_status, tx_done_irq;
  logic [7:0] rx_done_irq, rx_low_buffer_raw_status;
  logic [7:0] rx_low_buffer_irq_vector;
  logic [1:0] misc_irq_enable_set, misc_irq_enable_clear;
  logic [1:0] misc_irq_enable, misc_irq_raw_status;
  logic [127:0] rx_free_buffer_count, rx_flow_threshold;
  logic [35:0] stat_counter_msb;
  int n_errors = 0;
  int checks = 0;

  mac_dma_completion_irq_logic u_dut (.*);
  host_model u_host (.*);

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Both strobes are raised together; a zero pattern must change nothing.
  task automatic en(input int sel, input logic [7:0] s,
                    input logic [7:0] c);
    @(negedge clock);
    {tx_irq_enable_set_write, tx_irq_enable_clear_write} = {2{sel == 0}};
    {rx_irq_enable_set_write, rx_irq_enable_clear_write} = {2{sel == 1}};
    {misc_irq_enable_set_write, misc_irq_enable_clear_write} = {2{sel == 2}};
    tx_irq_enable_set   = s;
    rx_irq_enable_set   = s;
    misc_irq_enable_set = s[1:0];
    tx_irq_enable_clear   = c;
    rx_irq_enable_clear   = c;
    misc_irq_enable_clear = c[1:0];
    @(negedge clock);
    {tx_irq_enable_set_write, tx_irq_enable_clear_write} = 2'h0;
    {rx_irq_enable_set_write, rx_irq_enable_clear_write} = 2'h0;
    {misc_irq_enable_set_write, misc_irq_enable_clear_write} = 2'h0;
  endtask

  task automatic dma(input bit rx, input logic [2:0] ch,
                     input logic [31:0] a);
    @(negedge clock);
    tx_dma_write   = !rx;
    rx_dma_write   = rx;
    tx_dma_channel = ch;
    rx_dma_channel = ch;
    tx_dma_address = a;
    rx_dma_address = a;
    @(negedge clock);
    tx_dma_write   = 1'h0;
    rx_dma_write   = 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_enable(input int sel);
    en(sel, 8'hA5, 8'h00);
    chk("mask", 8'hA5, sel ? rx_irq_enable : tx_irq_enable);
    en(sel, 8'h00, 8'h00);
    chk("mask", 8'hA5, sel ? rx_irq_enable : tx_irq_enable);
    en(sel, 8'h0F, 8'h05);
    chk("mask", 8'hAF, sel ? rx_irq_enable : tx_irq_enable);
    en(sel, 8'h00, 8'hFF);
    chk("mask", 8'h00, sel ? rx_irq_enable : tx_irq_enable);
  endtask

  task automatic t_done(input bit rx, input logic [2:0] ch);
    logic [31:0] a;
    logic [31:0] b;
    a = 32'h10000040 + {29'h0, ch};
    b = a + 32'h00000020;
    en(rx, 8'hFF, 8'h00);
    tx_read_channel = ch;
    rx_read_channel = ch;
    dma(rx, ch, a);
    chk("raw", 8'h01 << ch,
        rx ? rx_irq_raw_status : tx_irq_raw_status);
    chk("irq", 8'h01 << ch, rx ? rx_done_irq : tx_done_irq);
    dma(rx, ch, b);
    @(negedge clock);
    chk("pointer", b,
        rx ? rx_completion_pointer : tx_completion_pointer);
    u_host.ack(rx, ch, a);
    @(negedge clock);
    chk("raw", 8'h01 << ch,
        rx ? rx_irq_raw_status : tx_irq_raw_status);
    chk("pointer", b,
        rx ? rx_completion_pointer : tx_completion_pointer);
    en(rx, 8'h00, 8'h01 << ch);
    chk("gated", 8'h00, rx ? rx_done_irq : tx_done_irq);
    chk("raw", 8'h01 << ch,
        rx ? rx_irq_raw_status : tx_irq_raw_status);
    u_host.ack(rx, ch, b);
    chk("raw", 8'h00,
        rx ? rx_irq_raw_status : tx_irq_raw_status);
    fork
      dma(rx, ch, a);
      begin
        @(negedge clock);
        u_host.ack(rx, ch, a);
      end
    join
    chk("raw", 8'h00, rx ? rx_irq_raw_status : tx_irq_raw_status);
  endtask

  task automatic t_thresh();
    en(1, 8'h0F, 8'hF0);
    for (int c = 0; c < 8; c++) begin
      rx_free_buffer_count[c*16 +: 16] = 16'h0010;
      rx_flow_threshold[c*16 +: 16] =
        (c < 3) ? 16'h0010 : ((c < 6) ? 16'h8010 : 16'h000F);
    end
    repeat (2) @(negedge clock);
    chk("low raw", 8'h3F, rx_low_buffer_raw_status);
    chk("low irq", 8'h0F, rx_low_buffer_irq_vector);
    rx_free_buffer_count[15:0] = 16'h0011;
    repeat (2) @(negedge clock);
    chk("low raw", 8'h3E, rx_low_buffer_raw_status);
    chk("low irq", 8'h0E, rx_low_buffer_irq_vector);
  endtask

  task automatic t_misc();
    en(2, 8'h03, 8'h00);
    chk("misc en", 2'h3, misc_irq_enable);
    stat_counter_msb[35] = 1'h1;
    repeat (2) @(negedge clock);
    chk("misc raw", 2'h1, misc_irq_raw_status);
    chk("overflow", 1'h1, counter_overflow_irq);
    en(2, 8'h00, 8'h01);
    chk("overflow", 1'h0, counter_overflow_irq);
    stat_counter_msb[35] = 1'h0;
    descriptor_error_event = 1'h1;
    @(negedge clock);
    descriptor_error_event = 1'h0;
    repeat (3) @(negedge clock);
    chk("misc raw", 2'h2, misc_irq_raw_status);
    chk("desc err", 1'h1, descriptor_error_irq);
    soft_reset = 1'h1;
    @(negedge clock);
    soft_reset = 1'h0;
    @(negedge clock);
    chk("misc raw", 2'h0, misc_irq_raw_status);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end

  initial begin
    reset = 1'h1;
    {tx_dma_write, rx_dma_write, soft_reset, descriptor_error_event} = 4'h0;
    {tx_dma_channel, rx_dma_channel, tx_read_channel} = 9'h000;
    rx_read_channel = 3'h0;
    {tx_dma_address, rx_dma_address} = 64'h0;
    {tx_irq_enable_set_write, tx_irq_enable_clear_write} = 2'h0;
    {rx_irq_enable_set_write, rx_irq_enable_clear_write} = 2'h0;
    {misc_irq_enable_set_write, misc_irq_enable_clear_write} = 2'h0;
    {tx_irq_enable_set, tx_irq_enable_clear} = 16'h0000;
    {rx_irq_enable_set, rx_irq_enable_clear} = 16'h0000;
    {misc_irq_enable_set, misc_irq_enable_clear} = 4'h0;
    rx_free_buffer_count = {8{16'hFFFF}};
    rx_flow_threshold = 128'h0;
    stat_counter_msb = 36'h0;
    repeat (8) @(negedge clock);
    reset = 1'h0;
    chk("enables", 18'h0,
        {tx_irq_enable, rx_irq_enable, misc_irq_enable});
    chk("pointer", 32'h0, tx_completion_pointer);
    t_enable(0);
    t_enable(1);
    t_done(0, 3'h2);
    t_done(1, 3'h7);
    t_done(1, 3'h0);
    t_thresh();
    t_misc();
    give_verdict();
  end
endmodule

`default_nettype wire

//--- hw/completion_channel.sv
// One DMA channel's completion pointer and pending interrupt.
// Assumes the DMA and host writes arrive as single-cycle strobes.

`default_nettype none

module completion_channel #(
  parameter int ADDRESS_WIDTH = irq_event_pkg::ADDRESS_WIDTH
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset,
  // DMA writes its last descriptor address
  input  wire logic                     dma_write,
  input  wire logic [ADDRESS_WIDTH-1:0] dma_address,
  // Host acknowledge
  input  wire logic                     host_write,
  input  wire logic [ADDRESS_WIDTH-1:0] host_address,
  // State
  output var  logic [ADDRESS_WIDTH-1:0] pointer,
  output var  logic                     pending,
  output logic                          next_pending
);

  logic [ADDRESS_WIDTH-1:0] next_pointer;
  logic                     ack_match;

  // The host value is compared, never stored.
  always_comb begin
    next_pointer = dma_write ? dma_address : pointer; // R7 R13
    ack_match    = host_write && (host_address == pointer); // R6 R12
    next_pending = pending;
    if (ack_match) begin
      next_pending = 1'b0; // R6 R12
    end
    // A new completion wins over an acknowledge in the same cycle.
    if (dma_write) begin
      next_pending = 1'b1; // R5 R11
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pointer <= ADDRESS_WIDTH'(irq_event_pkg::POINTER_RESET);
      pending <= 1'b0;
    end else begin
      pointer <= next_pointer;
      pending <= next_pending; // R2 R8
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_dma_done;
    dma_write;
  endsequence
  sequence s_ack_hit;
    host_write && !dma_write && host_address == pointer;
  endsequence

  a_dma_raises: assert property (s_dma_done |=> pending) // R5
    else $error("completion write did not raise pending");
  a_ack_clears: assert property (s_ack_hit |=> !pending) // R6
    else $error("matching acknowledge did not clear");
  a_ack_miss_holds: assert property (pending && !(host_write &&
    host_address == pointer) |=> pending) // R2
    else $error("pending dropped without matching acknowledge");
  a_host_blind: assert property (!dma_write |=>
    pointer == $past(pointer)) // R7
    else $error("pointer changed without a DMA write");
  a_full_cycle: assert property (s_dma_done ##1 s_ack_hit |=>
    !pending && pointer == $past(dma_address, 2)) // R12
    else $error("completion then acknowledge misbehaved");

endmodule

`default_nettype wire

//--- hw/irq_enable_mask.sv
// Per-bit interrupt enable mask with separate set and clear strobes.
// Assumes set and clear strobes are single-cycle and synchronous.

`default_nettype none

module irq_enable_mask #(
  parameter int WIDTH = irq_event_pkg::CHANNELS
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Set and clear strobes with their bit patterns
  input  wire logic             set_write,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic             clear_write,
  input  wire logic [WIDTH-1:0] clear_bits,
  // Current and next mask
  output var  logic [WIDTH-1:0] mask,
  output logic      [WIDTH-1:0] next_mask
);

  if (WIDTH < 1 || WIDTH > 8) begin : g_check
    $error("irq_enable_mask: WIDTH must be 1 to 8");
  end

  // A set in the same cycle as a clear of the same bit wins.
  always_comb begin
    next_mask = mask;
    if (clear_write) begin
      next_mask = next_mask & ~clear_bits; // R3 R9 R16
    end
    if (set_write) begin
      next_mask = next_mask | set_bits; // R3 R9 R16 R21
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mask <= WIDTH'(irq_event_pkg::ENABLE_RESET);
    end else begin
      mask <= next_mask;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_set_enables: assert property (set_write |=>
    (mask & $past(set_bits)) == $past(set_bits)) // R3
    else $error("set bit did not enable");
  a_clear_disables: assert property (clear_write && !set_write |=>
    (mask & $past(clear_bits)) == '0) // R9
    else $error("clear bit did not disable");
  a_zero_keeps: assert property (!set_write && !clear_write |=>
    mask == $past(mask)) // R21
    else $error("mask changed without a write");

endmodule

`default_nettype wire

//--- hw/irq_event_pkg.sv
// Shared constants of the DMA completion and threshold interrupt logic.
// Assumes one 100 MHz clock and a synchronous, active-high reset.
//
// What this block does
// (R1) Twenty-six interrupt sources in total.
// (R2) Transmit completion interrupt holds until acknowledged.
// (R3) Transmit enable set and clear per channel.
// (R4) Transmit status readable raw and gated.
// (R5) DMA pointer write raises transmit interrupt.
// (R6) Matching host acknowledge clears transmit interrupt.
// (R7) Host write never alters transmit pointer.
// (R8) Receive completion interrupt holds until acknowledged.
// (R9) Receive enable set and clear per channel.
// (R10) Receive status readable raw and gated.
// (R11) DMA pointer write raises receive interrupt.
// (R12) Matching host acknowledge clears receive interrupt.
// (R13) Host write never alters receive pointer.
// (R14) Host may acknowledge several packets at once.
// (R15) Per-channel threshold interrupt holds while condition.
// (R16) Threshold uses receive enables; raw and gated.
// (R17) Threshold asserts when free count at most threshold.
// (R18) Threshold shares flow-control compare, separate enable.
// (R19) Overflow interrupt while any counter MSB set.
// (R20) Descriptor error sticky until soft or hard reset.
// (R21) Zero bits leave enables; enables are readable.
// (R22) Gated output is raw AND enable every cycle.

`default_nettype none

package irq_event_pkg;
  localparam int CHANNELS      = 8;
  localparam int ADDRESS_WIDTH = 32;
  localparam int COUNT_WIDTH   = 16;
  localparam int STAT_COUNTERS = 36;
  localparam int IRQ_SOURCES   = 26;
  localparam int MISC_WIDTH    = 2;
  localparam int MISC_OVERFLOW = 0;
  localparam int MISC_DESC_ERR = 1;
  localparam logic [7:0]  ENABLE_RESET  = 8'h00;
  localparam logic [1:0]  MISC_RESET    = 2'h0;
  localparam logic [31:0] POINTER_RESET = 32'h00000000;
endpackage

`default_nettype wire

//--- hw/mac_dma_completion_irq_logic.sv
// Interrupt events of the eight-channel transmit and receive DMA engines.
// Assumes DMA and host strobes are synchronous single-cycle pulses and the
// flow-control counts and statistics MSBs are synchronous levels.

`default_nettype none

module mac_dma_completion_irq_logic #(
  parameter int CHANNELS      = irq_event_pkg::CHANNELS,
  parameter int ADDRESS_WIDTH = irq_event_pkg::ADDRESS_WIDTH,
  parameter int COUNT_WIDTH   = irq_event_pkg::COUNT_WIDTH,
  parameter int STAT_COUNTERS = irq_event_pkg::STAT_COUNTERS,
  localparam int CB           = $clog2(CHANNELS),
  localparam int MW           = irq_event_pkg::MISC_WIDTH
) (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            reset,
  // Transmit DMA completion writes
  input  wire logic                            tx_dma_write,
  input  wire logic [CB-1:0]                   tx_dma_channel,
  input  wire logic [ADDRESS_WIDTH-1:0]        tx_dma_address,
  // Transmit host acknowledge and pointer read
  input  wire logic                            tx_host_write,
  input  wire logic [CB-1:0]                   tx_host_channel,
  input  wire logic [ADDRESS_WIDTH-1:0]        tx_host_address,
  input  wire logic [CB-1:0]                   tx_read_channel,
  // Receive DMA completion writes
  input  wire logic                            rx_dma_write,
  input  wire logic [CB-1:0]                   rx_dma_channel,
  input  wire logic [ADDRESS_WIDTH-1:0]        rx_dma_address,
  // Receive host acknowledge and pointer read
  input  wire logic                            rx_host_write,
  input  wire logic [CB-1:0]                   rx_host_channel,
  input  wire logic [ADDRESS_WIDTH-1:0]        rx_host_address,
  input  wire logic [CB-1:0]                   rx_read_channel,
  // Transmit enable controls
  input  wire logic                            tx_irq_enable_set_write,
  input  wire logic [CHANNELS-1:0]             tx_irq_enable_set,
  input  wire logic                            tx_irq_enable_clear_write,
  input  wire logic [CHANNELS-1:0]             tx_irq_enable_clear,
  // Receive enable controls, shared by completion and threshold
  input  wire logic                            rx_irq_enable_set_write,
  input  wire logic [CHANNELS-1:0]             rx_irq_enable_set,
  input  wire logic                            rx_irq_enable_clear_write,
  input  wire logic [CHANNELS-1:0]             rx_irq_enable_clear,
  // Overflow and descriptor error enable controls
  input  wire logic                            misc_irq_enable_set_write,
  input  wire logic [MW-1:0]                   misc_irq_enable_set,
  input  wire logic                            misc_irq_enable_clear_write,
  input  wire logic [MW-1:0]                   misc_irq_enable_clear,
  // Receive flow-control state
  input  wire logic [CHANNELS*COUNT_WIDTH-1:0] rx_free_buffer_count,
  input  wire logic [CHANNELS*COUNT_WIDTH-1:0] rx_flow_threshold,
  // Statistics and descriptor checks
  input  wire logic [STAT_COUNTERS-1:0]        stat_counter_msb,
  input  wire logic                            descriptor_error_event,
  input  wire logic                            soft_reset,
  // Pointer read data
  output var  logic [ADDRESS_WIDTH-1:0]        tx_completion_pointer,
  output var  logic [ADDRESS_WIDTH-1:0]        rx_completion_pointer,
  // Enable masks as read back
  output var  logic [CHANNELS-1:0]             tx_irq_enable,
  output var  logic [CHANNELS-1:0]             rx_irq_enable,
  output var  logic [MW-1:0]                   misc_irq_enable,
  // Raw status views
  output var  logic [CHANNELS-1:0]             tx_irq_raw_status,
  output var  logic [CHANNELS-1:0]             rx_irq_raw_status,
  output var  logic [CHANNELS-1:0]             rx_low_buffer_raw_status,
  output var  logic [MW-1:0]                   misc_irq_raw_status,
  // Gated interrupt outputs
  output var  logic [CHANNELS-1:0]             tx_done_irq,
  output var  logic [CHANNELS-1:0]             rx_done_irq,
  output var  logic [CHANNELS-1:0]             rx_low_buffer_irq_vector,
  output var  logic                            counter_overflow_irq,
  output var  logic                            descriptor_error_irq
);

  if (CHANNELS < 2 || CHANNELS > 8 || (CHANNELS & (CHANNELS - 1)) != 0)
  begin : g_check_channels
    $error("CHANNELS must be 2, 4 or 8");
  end
  if (ADDRESS_WIDTH < 1 || COUNT_WIDTH < 1 || STAT_COUNTERS < 1)
  begin : g_check_widths
    $error("widths and counter count must be positive");
  end

  if (irq_event_pkg::IRQ_SOURCES != 3 * irq_event_pkg::CHANNELS + MW)
  begin : g_check_sources // R1
    $error("source count does not add up");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable masks

  logic [CHANNELS-1:0] next_tx_enable;
  logic [CHANNELS-1:0] next_rx_enable;
  logic [MW-1:0]       next_misc_enable;

  irq_enable_mask #(.WIDTH(CHANNELS)) tx_mask (
    .clock       (clock),
    .reset       (reset),
    .set_write   (tx_irq_enable_set_write),
    .set_bits    (tx_irq_enable_set),
    .clear_write (tx_irq_enable_clear_write),
    .clear_bits  (tx_irq_enable_clear),
    .mask        (tx_irq_enable),
    .next_mask   (next_tx_enable)
  );

  irq_enable_mask #(.WIDTH(CHANNELS)) rx_mask (
    .clock       (clock),
    .reset       (reset),
    .set_write   (rx_irq_enable_set_write),
    .set_bits    (rx_irq_enable_set),
    .clear_write (rx_irq_enable_clear_write),
    .clear_bits  (rx_irq_enable_clear),
    .mask        (rx_irq_enable),
    .next_mask   (next_rx_enable)
  );

  irq_enable_mask #(.WIDTH(MW)) misc_mask (
    .clock       (clock),
    .reset       (reset),
    .set_write   (misc_irq_enable_set_write),
    .set_bits    (misc_irq_enable_set),
    .clear_write (misc_irq_enable_clear_write),
    .clear_bits  (misc_irq_enable_clear),
    .mask        (misc_irq_enable),
    .next_mask   (next_misc_enable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Completion channels

  logic [CHANNELS-1:0]                    next_tx_pending;
  logic [CHANNELS-1:0]                    next_rx_pending;
  logic [CHANNELS-1:0][ADDRESS_WIDTH-1:0] tx_pointer;
  logic [CHANNELS-1:0][ADDRESS_WIDTH-1:0] rx_pointer;

  // Raw completion status lives in the channel flip-flops themselves.
  for (genvar c = 0; c < CHANNELS; c++) begin : g_channel
    completion_channel #(.ADDRESS_WIDTH(ADDRESS_WIDTH)) tx_channel (
      .clock        (clock),
      .reset        (reset),
      .dma_write    (tx_dma_write && tx_dma_channel == CB'(c)), // R5
      .dma_address  (tx_dma_address),
      .host_write   (tx_host_write && tx_host_channel == CB'(c)), // R6
      .host_address (tx_host_address),
      .pointer      (tx_pointer[c]),
      .pending      (tx_irq_raw_status[c]), // R2 R4
      .next_pending (next_tx_pending[c])
    );

    completion_channel #(.ADDRESS_WIDTH(ADDRESS_WIDTH)) rx_channel (
      .clock        (clock),
      .reset        (reset),
      .dma_write    (rx_dma_write && rx_dma_channel == CB'(c)), // R11
      .dma_address  (rx_dma_address),
      .host_write   (rx_host_write && rx_host_channel == CB'(c)), // R12
      .host_address (rx_host_address),
      .pointer      (rx_pointer[c]),
      .pending      (rx_irq_raw_status[c]), // R8 R10
      .next_pending (next_rx_pending[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold, overflow, descriptor error and gating

  logic [CHANNELS-1:0] next_low_raw;
  logic [MW-1:0]       next_misc_raw;
  logic [CHANNELS-1:0] next_tx_done;
  logic [CHANNELS-1:0] next_rx_done;
  logic [CHANNELS-1:0] next_low_irq;
  logic [MW-1:0]       next_misc_irq;

  // The compare is the flow-control one; only the enable differs, so a
  // channel with flow control off still reports running low.
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      next_low_raw[c] = rx_free_buffer_count[c*COUNT_WIDTH +: COUNT_WIDTH]
                        <= rx_flow_threshold[c*COUNT_WIDTH +: COUNT_WIDTH];
    end // R15 R17 R18
    next_misc_raw = misc_irq_raw_status;
    next_misc_raw[irq_event_pkg::MISC_OVERFLOW] = |stat_counter_msb; // R19
    if (soft_reset) begin
      next_misc_raw[irq_event_pkg::MISC_DESC_ERR] = 1'b0; // R20
    end
    if (descriptor_error_event) begin
      next_misc_raw[irq_event_pkg::MISC_DESC_ERR] = 1'b1; // R20
    end
    next_tx_done  = next_tx_pending & next_tx_enable; // R22 R4
    next_rx_done  = next_rx_pending & next_rx_enable; // R22 R10
    next_low_irq  = next_low_raw & next_rx_enable; // R16 R22
    next_misc_irq = next_misc_raw & next_misc_enable; // R22
  end

  // Twenty-six sources: eight each of three kinds, plus two.
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_low_buffer_raw_status <= '0;
      misc_irq_raw_status      <= irq_event_pkg::MISC_RESET;
      tx_done_irq              <= '0;
      rx_done_irq              <= '0;
      rx_low_buffer_irq_vector <= '0;
      counter_overflow_irq     <= 1'b0;
      descriptor_error_irq     <= 1'b0;
    end else begin
      rx_low_buffer_raw_status <= next_low_raw;
      misc_irq_raw_status      <= next_misc_raw;
      tx_done_irq              <= next_tx_done; // R1
      rx_done_irq              <= next_rx_done; // R1
      rx_low_buffer_irq_vector <= next_low_irq; // R1
      counter_overflow_irq     <= next_misc_irq[irq_event_pkg::MISC_OVERFLOW];
      descriptor_error_irq     <= next_misc_irq[irq_event_pkg::MISC_DESC_ERR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion pointer read port

  logic [ADDRESS_WIDTH-1:0] next_tx_read;
  logic [ADDRESS_WIDTH-1:0] next_rx_read;

  // Reads show the DMA-written value, the one an acknowledge must match.
  always_comb begin
    next_tx_read = tx_pointer[tx_read_channel]; // R7
    next_rx_read = rx_pointer[rx_read_channel]; // R13
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_completion_pointer <= ADDRESS_WIDTH'(irq_event_pkg::POINTER_RESET);
      rx_completion_pointer <= ADDRESS_WIDTH'(irq_event_pkg::POINTER_RESET);
    end else begin
      tx_completion_pointer <= next_tx_read;
      rx_completion_pointer <= next_rx_read;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_tx_done_write;
    tx_dma_write;
  endsequence
  sequence s_rx_done_write;
    rx_dma_write;
  endsequence

  a_tx_write_raises: assert property (s_tx_done_write |=>
    tx_irq_raw_status[$past(tx_dma_channel)]) // R5
    else $error("transmit completion did not raise raw status");
  a_rx_write_raises: assert property (s_rx_done_write |=>
    rx_irq_raw_status[$past(rx_dma_channel)]) // R11
    else $error("receive completion did not raise raw status");

  a_tx_gate_and: assert property (
    tx_done_irq == (tx_irq_raw_status & tx_irq_enable)) // R22
    else $error("transmit gated view differs from raw and enable");
  a_rx_gate_and: assert property (
    rx_done_irq == (rx_irq_raw_status & rx_irq_enable)) // R10
    else $error("receive gated view differs from raw and enable");
  a_low_gate_and: assert property (rx_low_buffer_irq_vector ==
    (rx_low_buffer_raw_status & rx_irq_enable)) // R16
    else $error("threshold gated view differs from raw and enable");

  a_low_compare: assert property (##1 rx_low_buffer_raw_status[0] ==
    ($past(rx_free_buffer_count[COUNT_WIDTH-1:0]) <=
     $past(rx_flow_threshold[COUNT_WIDTH-1:0]))) // R17
    else $error("threshold status does not follow the compare");

  a_overflow_level: assert property (|stat_counter_msb |=>
    counter_overflow_irq ==
    misc_irq_enable[irq_event_pkg::MISC_OVERFLOW]) // R19
    else $error("overflow interrupt does not follow counter MSB");

  a_desc_error_sticky: assert property (
    misc_irq_raw_status[irq_event_pkg::MISC_DESC_ERR] && !soft_reset |=>
    misc_irq_raw_status[irq_event_pkg::MISC_DESC_ERR]) // R20
    else $error("descriptor error cleared without soft reset");
  a_desc_error_sets: assert property (descriptor_error_event |=>
    misc_irq_raw_status[irq_event_pkg::MISC_DESC_ERR]) // R20
    else $error("descriptor error not set");
  a_soft_reset_clears: assert property (soft_reset &&
    !descriptor_error_event |=>
    !misc_irq_raw_status[irq_event_pkg::MISC_DESC_ERR]) // R20
    else $error("soft reset did not clear");

  a_tx_read_value: assert property (s_tx_done_write ##1
    (tx_read_channel == $past(tx_dma_channel) && !tx_dma_write) |=>
    tx_completion_pointer == $past(tx_dma_address, 2)) // R7
    else $error("transmit pointer read differs from DMA value");
  a_rx_read_value: assert property (s_rx_done_write ##1
    (rx_read_channel == $past(rx_dma_channel) && !rx_dma_write) |=>
    rx_completion_pointer == $past(rx_dma_address, 2)) // R13
    else $error("receive pointer read is wrong");

endmodule

`default_nettype wire
